/* File: pkg/ump_map.svh */
`ifndef UMP_MAP_SVH
`define UMP_MAP_SVH
// Register byte addresses
`define UMP_ADDR_CTRL    4'h0
`define UMP_ADDR_STATUS  4'h4
`define UMP_ADDR_MASK    4'h8
`define UMP_ADDR_DATA    4'hC
// Control field positions
`define UMP_CTRL_DIV_LO  0
`define UMP_CTRL_DIV_HI  7
`define UMP_CTRL_MODE_LO 8
`define UMP_CTRL_MODE_HI 9
`define UMP_CTRL_RE      10
`define UMP_CTRL_MCE     11
// Status bit positions
`define UMP_ST_RX        0
`define UMP_ST_FERR      1
`define UMP_ST_NINTH     2
// Oversampling figures
`define UMP_OVS_LAST     4'hF
`define UMP_OVS_MID      4'h7
// Index of the eighth data bit
`define UMP_LAST_DATA_BIT 3'h7
// AXI response codes
`define UMP_RESP_OKAY    2'h0
`define UMP_RESP_SLVERR  2'h2
`endif

/* File: pkg/ump_pkg.sv */
package ump_pkg;
  // Serial port operating modes
  typedef enum logic [1:0] {
    UMP_MODE0 = 2'h0,
    UMP_MODE1 = 2'h1,
    UMP_MODE2 = 2'h2,
    UMP_MODE3 = 2'h3
  } ump_mode_t;
  // Receiver sequencing
  typedef enum logic [2:0] {
    UMP_IDLE,
    UMP_START,
    UMP_DATA,
    UMP_NINTH,
    UMP_STOP
  } ump_rx_state_t;
endpackage : ump_pkg

/* File: pkg/ump_tick_if.sv */
`timescale 1ns/1ps
// Oversampling tick between divider and receiver
interface ump_tick_if;
  logic       tick;
  logic [1:0] mode;
  logic [7:0] divider;
  modport gen (input mode, input divider, output tick);
  modport use_side (output mode, output divider, input tick);
endinterface : ump_tick_if

/* File: hw/ump_baud_gen.sv */
`timescale 1ns/1ps
`include "ump_map.svh"
module ump_baud_gen
  import ump_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Tick carrier
  ump_tick_if.gen  tif
);
  logic [7:0] cnt_ff;          // Divider countdown
  logic [7:0] nxt_cnt;
  logic [7:0] reload;          // Reload per mode
  logic       wrap;
  // Mode 2 runs straight off the clock
  assign reload  = (tif.mode == UMP_MODE2) ? 8'h00 : tif.divider;
  assign wrap    = (cnt_ff == 8'h00);
  assign nxt_cnt = wrap ? reload : cnt_ff - 8'h01;
  assign tif.tick = wrap;
  // Counter keeps running so ticks are free-running
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cnt_ff <= 8'h00;
    else         cnt_ff <= nxt_cnt;
  end
endmodule : ump_baud_gen

/* File: hw/ump_rx_filter.sv */
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "ump_map.svh"
module ump_rx_filter
  import ump_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Serial line
  input  wire logic        rxd,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt
  output logic             irq
);
  // Line synchroniser
  logic       rx_meta_ff;      // First stage, read by second only
  logic       rx_sync_ff;      // Safe line level
  // Software registers
  logic [7:0] baud_divider_value_ff;
  logic [1:0] mode_ff;
  logic       receive_enable_bit_ff;
  logic       multiproc_filter_enable_ff;
  logic [2:0] status_ff;       // Sticky events
  logic [2:0] mask_ff;         // Interrupt gates
  logic [7:0] rx_data_ff;      // Received byte
  logic       rx_ninth_bit_flag_ff;
  // Receiver state
  ump_rx_state_t state_ff;
  logic [3:0] ovs_ff;          // Position in bit
  logic [2:0] bit_ff;          // Data bit index
  logic [7:0] shift_ff;        // Incoming byte
  // Bus state
  logic       aw_hold_ff;
  logic       w_hold_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;        // Lanes kept with held data
  logic       bvalid_ff;
  logic [1:0] bresp_ff;
  logic       rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  // Divider
  ump_tick_if tif ();
  assign tif.mode    = mode_ff;
  assign tif.divider = baud_divider_value_ff;
  ump_baud_gen u_baud (
    .clk    (clk),
    .resetn (resetn),
    .tif    (tif)
  );
  // Two-stage synchroniser on the pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rxd;
      rx_sync_ff <= rx_meta_ff;
    end
  end
  // Receive path decode
  wire nine_bit   = mode_ff[1];
  wire async_mode = (mode_ff != UMP_MODE0);
  wire mid        = tif.tick && (ovs_ff == `UMP_OVS_MID);
  wire last_ovs   = tif.tick && (ovs_ff == `UMP_OVS_LAST);
  wire stop_mid   = (state_ff == UMP_STOP) && mid;
  // Filter: ninth bit in 9-bit modes, stop bit in mode 1
  wire gate_bit   = nine_bit ? rx_ninth_bit_flag_ff : rx_sync_ff;
  wire rx_event   = stop_mid && (!multiproc_filter_enable_ff || gate_bit);
  wire ferr_event = stop_mid && !rx_sync_ff;
  // Receiver sequencer; mode 0 never leaves UMP_IDLE and has no shift clocking
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= UMP_IDLE;
      ovs_ff   <= 4'h0;
      bit_ff   <= 3'h0;
      shift_ff <= 8'h00;
    end else begin
      case (state_ff)
        UMP_IDLE: begin
          ovs_ff <= 4'h0;
          bit_ff <= 3'h0;
          // Falling line starts a frame
          if (receive_enable_bit_ff && async_mode && !rx_sync_ff) state_ff <= UMP_START;
        end
        UMP_START: begin
          if (tif.tick) ovs_ff <= ovs_ff + 4'h1;
          // Glitch shorter than half a bit is dropped
          if (mid && rx_sync_ff) state_ff <= UMP_IDLE;
          else if (last_ovs) state_ff <= UMP_DATA;
        end
        UMP_DATA: begin
          if (tif.tick) ovs_ff <= ovs_ff + 4'h1;
          if (mid) shift_ff <= {rx_sync_ff, shift_ff[7:1]};  // LSB first
          if (last_ovs) begin
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == `UMP_LAST_DATA_BIT) state_ff <= nine_bit ? UMP_NINTH : UMP_STOP;
          end
        end
        UMP_NINTH: begin
          if (tif.tick) ovs_ff <= ovs_ff + 4'h1;
          if (last_ovs) state_ff <= UMP_STOP;
        end
        UMP_STOP: begin
          if (tif.tick) ovs_ff <= ovs_ff + 4'h1;
          // Return at mid-stop so the next start edge is not missed
          if (mid) state_ff <= UMP_IDLE;
        end
        default: state_ff <= UMP_IDLE;
      endcase
    end
  end
  // Captured frame results
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_ninth_bit_flag_ff <= 1'b0;
      rx_data_ff           <= 8'h00;
    end else begin
      if (state_ff == UMP_NINTH && mid) rx_ninth_bit_flag_ff <= rx_sync_ff;
      else if (stop_mid && !nine_bit) rx_ninth_bit_flag_ff <= rx_sync_ff;
      if (stop_mid) rx_data_ff <= shift_ff;
    end
  end
  // Bus write decode
  wire aw_have  = aw_hold_ff || s_axi_awvalid;
  wire w_have   = w_hold_ff || s_axi_wvalid;
  wire [3:0]  wa = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd = w_hold_ff ? wdata_ff : s_axi_wdata;
  // Strobes must travel with held data or a late address uses stale lanes
  wire [3:0]  ws = w_hold_ff ? wstrb_ff : s_axi_wstrb;
  wire do_wr    = aw_have && w_have && !bvalid_ff;
  wire wr_ctrl  = do_wr && (wa == `UMP_ADDR_CTRL);
  wire wr_stat  = do_wr && (wa == `UMP_ADDR_STATUS) && ws[0];
  wire wr_mask  = do_wr && (wa == `UMP_ADDR_MASK) && ws[0];
  wire wr_ok    = (wa == `UMP_ADDR_CTRL) || (wa == `UMP_ADDR_STATUS) ||
                  (wa == `UMP_ADDR_MASK) || (wa == `UMP_ADDR_DATA);
  // Fresh bit used: in mode 1 the flag is only loaded on this same edge
  wire [2:0] ev = {rx_event && gate_bit, ferr_event, rx_event};
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign irq           = |(status_ff & mask_ff);
  // Write channel holding and response
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 4'h0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `UMP_RESP_OKAY;
    end else begin
      if (do_wr) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_ok ? `UMP_RESP_OKAY : `UMP_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_ff <= 1'b1;
          awaddr_ff  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_ff <= 1'b1;
          wdata_ff  <= s_axi_wdata;
          wstrb_ff  <= s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) bvalid_ff <= 1'b0;
      end
    end
  end
  // Control, mask and sticky status; set beats clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      baud_divider_value_ff      <= 8'h00;
      mode_ff                    <= 2'h0;
      receive_enable_bit_ff      <= 1'b0;
      multiproc_filter_enable_ff <= 1'b0;
      status_ff                  <= 3'h0;
      mask_ff                    <= 3'h0;
    end else begin
      if (wr_ctrl && ws[0]) baud_divider_value_ff <= wd[`UMP_CTRL_DIV_HI:`UMP_CTRL_DIV_LO];
      if (wr_ctrl && ws[1]) begin
        mode_ff                    <= wd[`UMP_CTRL_MODE_HI:`UMP_CTRL_MODE_LO];
        receive_enable_bit_ff      <= wd[`UMP_CTRL_RE];
        multiproc_filter_enable_ff <= wd[`UMP_CTRL_MCE];
      end
      if (wr_mask) mask_ff <= wd[2:0];
      status_ff <= (status_ff & ~(wr_stat ? wd[2:0] : 3'h0)) | ev;
    end
  end
  // Read channel
  wire [31:0] ctrl_rd = {20'h0_0000, multiproc_filter_enable_ff, receive_enable_bit_ff,
                         mode_ff, baud_divider_value_ff};
  wire [31:0] data_rd = {23'h00_0000, rx_ninth_bit_flag_ff, rx_data_ff};
  wire rd_ok = (s_axi_araddr == `UMP_ADDR_CTRL) || (s_axi_araddr == `UMP_ADDR_STATUS) ||
               (s_axi_araddr == `UMP_ADDR_MASK) || (s_axi_araddr == `UMP_ADDR_DATA);
  wire [31:0] rd_mux = (s_axi_araddr == `UMP_ADDR_CTRL)   ? ctrl_rd :
                       (s_axi_araddr == `UMP_ADDR_STATUS) ? {29'h0, status_ff} :
                       (s_axi_araddr == `UMP_ADDR_MASK)   ? {29'h0, mask_ff} :
                       (s_axi_araddr == `UMP_ADDR_DATA)   ? data_rd : 32'h0000_0000;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `UMP_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_ok ? `UMP_RESP_OKAY : `UMP_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule : ump_rx_filter

/* File: test/ump_rx_asserts.sv */
`timescale 1ns/1ps
module ump_rx_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Interrupt
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Address and data taken on one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_B_ANSWER: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write response late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  // Only a software write can take the interrupt down
  AST_IRQ_CLEAR: assert property ($fell(irq) |-> $past(s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready))
    else $error("interrupt fell without a write");
endmodule : ump_rx_asserts

bind ump_rx_filter ump_rx_asserts ump_rx_asserts_inst (.clk, .resetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq);

/* File: test/ump_line_model.sv */
`timescale 1ns/1ps
module ump_line_model (
  // Bus clock
  input wire logic clk,
  // Line towards the receiver
  output logic     rxd
);
  // Line idles high between frames
  initial rxd = 1'h1;
  // One frame, each bit held per clocks
  task send(input logic [7:0] d, input logic nine, input logic b9, input logic stop,
            input int per);
    logic [9:0] bits;
    bits = {b9, d, 1'h0};
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      rxd <= bits[i];
      repeat (per) @(posedge clk);
    end
    rxd <= stop;
    // Bad stop ends early so no false start follows
    repeat (stop ? per : per * 5 / 8) @(posedge clk);
    rxd <= 1'h1;
    repeat (stop ? 0 : per - per * 5 / 8) @(posedge clk);
  endtask : send
endmodule : ump_line_model

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
  // Stimulus and observed signals
  logic        clk, resetn, rxd, irq;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          n_fail, n_tests, cycles;

  ump_rx_filter ump_rx_filter_inst (.clk, .resetn, .rxd, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  ump_line_model ump_line_model_inst (.clk, .rxd);

  // 50 ns clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Write; response ready offered with the request and held until answered
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    bs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  // Read; data ready offered with the request and held until answered
  task rd(input logic [3:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  // Configure, send one frame, check and clear status
  task frame(input string name, input logic [31:0] ctrl, input logic [7:0] d,
             input logic nine, input logic b9, input logic stop, input int per,
             input logic [31:0] st, input logic [31:0] dat);
    wr(4'h0, ctrl);
    ump_line_model_inst.send(d, nine, b9, stop, per);
    repeat (4) @(posedge clk);
    chk({name, " irq"}, {31'h0, |st}, {31'h0, irq});
    rd(4'h4);
    chk({name, " status"}, st, rv);
    rd(4'hC);
    chk({name, " data"}, dat, rv);
    wr(4'h4, 32'h7);
    $display("test %s done", name);
  endtask : frame

  initial begin
    {resetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, n_fail, n_tests, cycles} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    rd(4'h0);
    chk("ctrl reset", 32'h0, rv);
    rd(4'h2);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    wr(4'h2, 32'h0);
    chk("unmapped wresp", 32'h2, {30'h0, bs});
    wr(4'h0, 32'h0);
    chk("mapped wresp", 32'h0, {30'h0, bs});
    $display("test reset and bus done");
    wr(4'h0, 32'hF01);
    ump_line_model_inst.send(8'h5A, 1'h1, 1'h1, 1'h1, 32);
    repeat (4) @(posedge clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(4'h8, 32'h7);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    rd(4'h4);
    chk("address status", 32'h5, rv);
    rd(4'hC);
    chk("address data", 32'h15A, rv);
    wr(4'h4, 32'h7);
    chk("cleared irq", 32'h0, {31'h0, irq});
    $display("test address frame done");
    frame("data filtered", 32'hF01, 8'hA5, 1'h1, 1'h0, 1'h1, 32, 32'h0, 32'h0A5);
    frame("slave accepts", 32'h701, 8'h3C, 1'h1, 1'h0, 1'h1, 32, 32'h1, 32'h03C);
    frame("mode2 rate", 32'hE05, 8'hC3, 1'h1, 1'h1, 1'h1, 16, 32'h5, 32'h1C3);
    frame("mode3 slow", 32'hF03, 8'h01, 1'h1, 1'h1, 1'h1, 64, 32'h5, 32'h101);
    frame("mode1 good stop", 32'hD01, 8'h42, 1'h0, 1'h0, 1'h1, 32, 32'h5, 32'h142);
    frame("mode1 bad stop", 32'hD01, 8'h81, 1'h0, 1'h0, 1'h0, 32, 32'h2, 32'h081);
    frame("mode0 ignored", 32'hC01, 8'h99, 1'h0, 1'h0, 1'h1, 32, 32'h0, 32'h081);
    end_of_test();
  end
endmodule : tb
